/* peci_fan_curve_and_ramp.sv */
// Implementation choice: the APB slave port.
`timescale 1ns/10ps
// Overview of operation
// - Above start temperature, run minimum then climb
// - Start temperature resets to 0xe0, minus 32
// - Lock makes start and span registers read-only
// - Ramp code caps duty change per update
// - Fast table steps 1,2,3,4,8,12,24,48
// - Config6 bit 7 selects slower ramp table
// - Ramp time scales with PECI refresh interval
// - Smoothing enable bit 3 gates ramp limiting
// - Bits 7 to 4 select curve span
// - Span and ramp register resets to 0xc0
// - Lock bit writable once, cleared only by reset
// - Refresh interval follows the averaging count field
module peci_fan_curve_and_ramp (
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] peci_reading,
  input wire logic peci_reading_valid,
  output logic fan_pulse_output
);

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [7:0] fan_start_temperature;
  fan_curve_pkg::span_ramp_s span_ramp;
  logic [2:0] reading_average_count;
  logic slow_ramp;
  logic locked;
  logic [7:0] minimum_fan_duty;
  logic [7:0] current_duty;
  logic [7:0] averaged_temperature;

  logic access;
  logic write_access;
  logic [9:0] index;
  logic mapped;

  assign access = psel && penable;
  assign write_access = access && pwrite;
  assign index = paddr[11:2];
  assign pready = 1'b1;

  always_comb begin
    case (index)
      fan_curve_pkg::config6_index,
      fan_curve_pkg::peci_config1_index,
      fan_curve_pkg::start_temperature_index,
      fan_curve_pkg::span_and_ramp_index,
      fan_curve_pkg::config1_index,
      fan_curve_pkg::minimum_duty_index,
      fan_curve_pkg::duty_status_index,
      fan_curve_pkg::temperature_status_index: mapped = (paddr[1:0] == 2'h0);
      default: mapped = 1'b0;
    endcase
  end

  assign pslverr = access && !mapped;

  // ****************************************************************
  // Register writes
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (reset) begin
      fan_start_temperature <= fan_curve_pkg::start_temperature_reset;
    end else if (write_access && !locked &&
                 index == fan_curve_pkg::start_temperature_index &&
                 mapped) begin
      fan_start_temperature <= pwdata[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      span_ramp <= fan_curve_pkg::span_and_ramp_reset;
    end else if (write_access && !locked &&
                 index == fan_curve_pkg::span_and_ramp_index &&
                 mapped) begin
      span_ramp <= pwdata[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      reading_average_count <= 3'h0;
    end else if (write_access && !locked &&
                 index == fan_curve_pkg::peci_config1_index && mapped) begin
      reading_average_count <= pwdata[2:0];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      slow_ramp <= 1'b0;
    end else if (write_access && index == fan_curve_pkg::config6_index &&
                 mapped) begin
      slow_ramp <= pwdata[fan_curve_pkg::slow_ramp_bit];
    end
  end

  // Only a reset, standing in for a power cycle, can release the lock
  always_ff @(posedge clock) begin
    if (reset) begin
      locked <= 1'b0;
    end else if (write_access && index == fan_curve_pkg::config1_index &&
                 mapped && pwdata[fan_curve_pkg::lock_bit]) begin
      locked <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      minimum_fan_duty <= fan_curve_pkg::minimum_duty_reset;
    end else if (write_access && !locked &&
                 index == fan_curve_pkg::minimum_duty_index && mapped) begin
      minimum_fan_duty <= pwdata[7:0];
    end
  end

  // ****************************************************************
  // Register reads
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (reset) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      // Loaded in setup, so data stands when the access edge samples it
      case (mapped ? index : 10'h3ff)
        fan_curve_pkg::config6_index:
          prdata <= {24'h0, slow_ramp, 7'h0};
        fan_curve_pkg::peci_config1_index:
          prdata <= {29'h0, reading_average_count};
        fan_curve_pkg::start_temperature_index:
          prdata <= {24'h0, fan_start_temperature};
        fan_curve_pkg::span_and_ramp_index:
          prdata <= {24'h0, span_ramp};
        fan_curve_pkg::config1_index:
          prdata <= {29'h0, 1'b1, locked, 1'b0};
        fan_curve_pkg::minimum_duty_index:
          prdata <= {24'h0, minimum_fan_duty};
        fan_curve_pkg::duty_status_index:
          prdata <= {24'h0, current_duty};
        fan_curve_pkg::temperature_status_index:
          prdata <= {24'h0, averaged_temperature};
        default:
          prdata <= 32'h0;
      endcase
    end
  end

  // ****************************************************************
  // Reading averaging and refresh
  // ****************************************************************
  logic [23:0] reading_sum;
  logic [16:0] reading_count;
  logic [16:0] readings_needed;
  logic [4:0] average_shift;
  logic [23:0] next_sum;
  logic refresh;

  always_comb begin
    case (reading_average_count)
      3'h0: average_shift = 5'h04;
      3'h1: average_shift = 5'h0b;
      3'h2: average_shift = 5'h0c;
      3'h3: average_shift = 5'h0d;
      3'h4: average_shift = 5'h0e;
      3'h5: average_shift = 5'h0f;
      default: average_shift = 5'h10;
    endcase
  end

  assign readings_needed = 17'h1 << average_shift;
  assign next_sum = reading_sum + {{16{peci_reading[7]}}, peci_reading};

  always_ff @(posedge clock) begin
    if (reset) begin
      reading_sum <= 24'h0;
      reading_count <= 17'h0;
      refresh <= 1'b0;
      averaged_temperature <= 8'h0;
    end else begin
      refresh <= 1'b0;
      if (peci_reading_valid) begin
        if (reading_count == readings_needed - 17'h1) begin
          averaged_temperature <= 8'($signed(next_sum) >>> average_shift);
          reading_sum <= 24'h0;
          reading_count <= 17'h0;
          refresh <= 1'b1;
        end else begin
          reading_sum <= next_sum;
          reading_count <= reading_count + 17'h1;
        end
      end
    end
  end

  // ****************************************************************
  // Duty curve
  // ****************************************************************
  // Span held in sixths of a degree so thirds stay exact
  logic [8:0] span_sixths;
  logic signed [8:0] delta;
  logic [10:0] delta_sixths;
  logic [18:0] curve_product;
  logic [7:0] duty_headroom;
  logic [7:0] next_target;
  logic [7:0] target_duty;
  logic ramp_due;

  always_comb begin
    case (span_ramp.curve_temperature_span)
      4'h0: span_sixths = 9'd12;
      4'h1: span_sixths = 9'd15;
      4'h2: span_sixths = 9'd20;
      4'h3: span_sixths = 9'd24;
      4'h4: span_sixths = 9'd30;
      4'h5: span_sixths = 9'd40;
      4'h6: span_sixths = 9'd48;
      4'h7: span_sixths = 9'd60;
      4'h8: span_sixths = 9'd80;
      4'h9: span_sixths = 9'd96;
      4'ha: span_sixths = 9'd120;
      4'hb: span_sixths = 9'd160;
      4'hc: span_sixths = 9'd192;
      4'hd: span_sixths = 9'd240;
      default: span_sixths = 9'd320;
    endcase
  end

  assign delta = $signed({averaged_temperature[7], averaged_temperature}) -
                 $signed({fan_start_temperature[7], fan_start_temperature});
  assign delta_sixths = 11'(delta[7:0] * 4'd6);
  // Plain net, so a new minimum duty reaches the product at once
  assign duty_headroom = fan_curve_pkg::full_duty - minimum_fan_duty;
  assign curve_product = 19'(duty_headroom * delta_sixths);

  always_comb begin
    if (delta <= 9'sd0) begin
      next_target = 8'h00;
    end else if (delta_sixths >= {2'h0, span_sixths}) begin
      next_target = fan_curve_pkg::full_duty;
    end else begin
      next_target = minimum_fan_duty +
                    8'(curve_product / {10'h0, span_sixths});
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      target_duty <= 8'h00;
      ramp_due <= 1'b0;
    end else begin
      ramp_due <= refresh;
      if (refresh) begin
        target_duty <= next_target;
      end
    end
  end

  // ****************************************************************
  // Ramp limiting
  // ****************************************************************
  // One step per refresh, so a slower refresh stretches the ramp
  logic [5:0] ramp_step;
  logic [5:0] ramp_scale;
  logic [11:0] ramp_total;
  logic [4:0] ramp_fraction;
  logic [6:0] ramp_move;
  logic [8:0] raised;
  logic [8:0] lowered;

  always_comb begin
    case (span_ramp.ramp_step_code)
      3'h0: ramp_step = 6'd1;
      3'h1: ramp_step = 6'd2;
      3'h2: ramp_step = 6'd3;
      3'h3: ramp_step = 6'd4;
      3'h4: ramp_step = 6'd8;
      3'h5: ramp_step = 6'd12;
      3'h6: ramp_step = 6'd24;
      default: ramp_step = 6'd48;
    endcase
  end

  assign ramp_scale = slow_ramp ? fan_curve_pkg::slow_ramp_scale :
                      fan_curve_pkg::fast_ramp_scale;
  assign ramp_total = 12'(ramp_step * ramp_scale) + {7'h0, ramp_fraction};
  assign ramp_move = ramp_total[11:fan_curve_pkg::ramp_fraction_bits];
  assign raised = {1'b0, current_duty} + {2'h0, ramp_move};
  assign lowered = {1'b0, current_duty} - {2'h0, ramp_move};

  always_ff @(posedge clock) begin
    if (reset) begin
      current_duty <= 8'h00;
      ramp_fraction <= 5'h0;
    end else if (ramp_due) begin
      if (!span_ramp.ramp_smoothing_enable) begin
        current_duty <= target_duty;
        ramp_fraction <= 5'h0;
      end else if (current_duty < target_duty) begin
        ramp_fraction <= ramp_total[4:0];
        current_duty <= (raised >= {1'b0, target_duty}) ?
                        target_duty : raised[7:0];
      end else if (current_duty > target_duty) begin
        ramp_fraction <= ramp_total[4:0];
        current_duty <= (lowered[8] || lowered[7:0] <= target_duty) ?
                        target_duty : lowered[7:0];
      end
    end
  end

  // ****************************************************************
  // Pulse output
  // ****************************************************************
  logic [3:0] pwm_divider;
  logic pwm_tick;
  logic [7:0] pwm_count;

  assign pwm_tick = (pwm_divider == 4'(fan_curve_pkg::pwm_tick_cycles - 1));

  always_ff @(posedge clock) begin
    if (reset) begin
      pwm_divider <= 4'h0;
      pwm_count <= 8'h00;
    end else begin
      pwm_divider <= pwm_tick ? 4'h0 : pwm_divider + 4'h1;
      if (pwm_tick) begin
        pwm_count <= pwm_count + 8'h01;
      end
    end
  end

  // Full duty must stay high through the wrap of the counter
  always_ff @(posedge clock) begin
    if (reset) begin
      fan_pulse_output <= 1'b0;
    end else begin
      fan_pulse_output <= (current_duty == fan_curve_pkg::full_duty) ||
                          (pwm_count < current_duty);
    end
  end

endmodule : peci_fan_curve_and_ramp

/* fan_curve_pkg.sv */
package fan_curve_pkg;

  // ****************************************************************
  // Register indices; byte address is four times the index
  // ****************************************************************
  localparam logic [9:0] config6_index = 10'h010;
  localparam logic [9:0] peci_config1_index = 10'h036;
  localparam logic [9:0] start_temperature_index = 10'h03b;
  localparam logic [9:0] span_and_ramp_index = 10'h03c;
  localparam logic [9:0] config1_index = 10'h040;
  localparam logic [9:0] minimum_duty_index = 10'h070;
  localparam logic [9:0] duty_status_index = 10'h071;
  localparam logic [9:0] temperature_status_index = 10'h072;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int lock_bit = 1;
  localparam int ready_bit = 2;
  localparam int slow_ramp_bit = 7;

  // ****************************************************************
  // Values after reset
  // ****************************************************************
  localparam logic [7:0] start_temperature_reset = 8'he0;
  localparam logic [7:0] span_and_ramp_reset = 8'hc0;
  localparam logic [7:0] minimum_duty_reset = 8'h80;
  localparam logic [7:0] full_duty = 8'hff;

  // ****************************************************************
  // Ramp timing
  // ****************************************************************
  localparam int round_robin_ms = 165;
  // Slow ramp table is about 23/32 of the fast rate
  localparam logic [5:0] fast_ramp_scale = 6'h20;
  localparam logic [5:0] slow_ramp_scale = 6'h17;
  localparam int ramp_fraction_bits = 5;
  localparam int pwm_tick_cycles = 16;

  typedef struct packed {
    logic [3:0] curve_temperature_span;
    logic ramp_smoothing_enable;
    logic [2:0] ramp_step_code;
  } span_ramp_s;

endpackage : fan_curve_pkg

/* fan_curve_sva.sv */
`timescale 1ns/10ps
// ****
// Port checks
// ****
module fan_curve_sva (
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] peci_reading,
  input wire logic peci_reading_valid,
  input wire logic fan_pulse_output
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  sequence access_s;
    psel && penable;
  endsequence
  sequence lock_write_s;
    access_s ##0 (pwrite && paddr == 12'h100 && pwdata[1]);
  endsequence
  sequence cfg1_read_s;
    access_s ##0 (!pwrite && paddr == 12'h100);
  endsequence
  AST_NO_WAIT: assert property (access_s |-> pready)
    else $error("pready low in access");
  AST_ERR_SCOPE: assert property (pslverr |-> access_s)
    else $error("pslverr outside access");
  AST_MISALIGNED: assert property (
    access_s ##0 paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access not refused");
  AST_UPPER_ZERO: assert property (prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  AST_MAPPED_OK: assert property (
    access_s ##0 (paddr == 12'h0ec || paddr == 12'h0f0) |-> !pslverr)
    else $error("mapped register refused");
  AST_LOCK_STICKS: assert property (
    lock_write_s ##3 cfg1_read_s |=> prdata[1])
    else $error("lock bit not held");
  AST_UNMAPPED_ZERO: assert property (
    access_s ##0 (!pwrite && pslverr) |=> prdata == 32'h0)
    else $error("refused read not zero");
  AST_READ_HOLDS: assert property (
    !(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved without read");
  AST_PWM_IDLE: assert property (
    disable iff (1'b0) reset |=> !fan_pulse_output)
    else $error("pwm high after reset");
endmodule : fan_curve_sva

bind peci_fan_curve_and_ramp fan_curve_sva checker_i (.clock(clock),
  .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .peci_reading(peci_reading),
  .peci_reading_valid(peci_reading_valid),
  .fan_pulse_output(fan_pulse_output));

/* peci_source.sv */
`timescale 1ns/10ps
// ****
// Processor temperature source
// ****
module peci_source (
  input wire logic clock,
  output logic [7:0] peci_reading,
  output logic peci_reading_valid
);
  initial begin
    peci_reading = 8'h00;
    peci_reading_valid = 1'b0;
  end
  // One full averaging window of 16 samples
  task automatic send(input logic [7:0] t);
    for (int i = 0; i < 16; i++) begin
      @(posedge clock);
      peci_reading <= t;
      peci_reading_valid <= 1'b1;
      @(posedge clock);
      // Off-sample value differs so stale data is not read as valid
      peci_reading <= ~t;
      peci_reading_valid <= 1'b0;
    end
    repeat (4) @(posedge clock);
  endtask : send
endmodule : peci_source

/* peci_fan_curve_and_ramp_tb.sv */
`timescale 1ns/10ps
module peci_fan_curve_and_ramp_tb;
  logic clock, reset, psel, penable, pwrite, pready, pslverr;
  logic fan_pulse_output, peci_reading_valid, err_seen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] peci_reading, got;
  int errors = 0;
  int compares = 0;
  int steps [8] = '{1, 2, 3, 4, 8, 12, 24, 48};
  int span6 [16] = '{12, 15, 20, 24, 30, 40, 48, 60, 80, 96, 120, 160,
    192, 240, 320, 320};
  peci_fan_curve_and_ramp DUT (.clock(clock), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .peci_reading(peci_reading), .peci_reading_valid(peci_reading_valid),
    .fan_pulse_output(fan_pulse_output));
  peci_source src (.clock(clock), .peci_reading(peci_reading),
    .peci_reading_valid(peci_reading_valid));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // ****
  // Bus tasks
  // ****
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [7:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) begin
      @(posedge clock);
    end
    // Taken at the edge that samples pready high, before release
    err_seen = pslverr;
    got = prdata[7:0];
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(got, e);
  endtask : rd
  task automatic final_report;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  initial begin
    #300000;
    errors++;
    final_report;
  end
  // ****
  // Tests
  // ****
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    rd(12'h0ec, 8'he0);
    rd(12'h0f0, 8'hc0);
    rd(12'h0ed, 8'h00);
    chk({7'h0, err_seen}, 8'h01);
    rd(12'h3fc, 8'h00);
    chk({7'h0, err_seen}, 8'h01);
    apb(1'b1, 12'h0ec, 8'h20);
    apb(1'b1, 12'h1c0, 8'h40);
    apb(1'b1, 12'h0d8, 8'h00);
    // One degree above start for every span code
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, 12'h0f0, {c[3:0], 4'h0});
      src.send(8'h21);
      rd(12'h1c4, 8'(64 + 1146 / span6[c]));
    end
    src.send(8'h10);
    rd(12'h1c4, 8'h00);
    @(negedge clock);
    chk({7'h0, fan_pulse_output}, 8'h00);
    src.send(8'h7f);
    rd(12'h1c4, 8'hff);
    rd(12'h1c8, 8'h7f);
    repeat (40) begin
      @(negedge clock);
      chk({7'h0, fan_pulse_output}, 8'h01);
    end
    // One refresh of smoothing from zero, fast table
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, 12'h0f0, 8'hc0);
      src.send(8'h10);
      apb(1'b1, 12'h0f0, 8'hc8 | 8'(k));
      src.send(8'h7f);
      rd(12'h1c4, 8'(steps[k]));
    end
    apb(1'b1, 12'h040, 8'h80);
    rd(12'h040, 8'h80);
    apb(1'b1, 12'h0f0, 8'hc0);
    src.send(8'h10);
    apb(1'b1, 12'h0f0, 8'hcf);
    src.send(8'h7f);
    rd(12'h1c4, 8'h22);
    src.send(8'h7f);
    rd(12'h1c4, 8'h45);
    apb(1'b1, 12'h100, 8'h02);
    apb(1'b0, 12'h100, 8'h00);
    chk(got & 8'h06, 8'h06);
    apb(1'b1, 12'h100, 8'h00);
    apb(1'b0, 12'h100, 8'h00);
    chk(got & 8'h06, 8'h06);
    apb(1'b1, 12'h0ec, 8'h55);
    rd(12'h0ec, 8'h20);
    apb(1'b1, 12'h0f0, 8'h3f);
    rd(12'h0f0, 8'hcf);
    // Reset in mid-run stands in for a power cycle
    @(posedge clock);
    reset <= 1'b1;
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    rd(12'h100, 8'h04);
    rd(12'h0ec, 8'he0);
    rd(12'h1c0, 8'h80);
    apb(1'b1, 12'h0ec, 8'h55);
    rd(12'h0ec, 8'h55);
    final_report;
  end
endmodule : peci_fan_curve_and_ramp_tb
